// ---- hw/slw_pkg.sv ----
// shared constants and types for the serial link wake and check code block
package slw_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WAKE_QUALIFY_TIME_NS = 240;
  localparam int WAKE_QUALIFY_CYC =
    (WAKE_QUALIFY_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int IDLE_TIMEOUT_US = 5500;
  localparam int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * CLK_MHZ;
  localparam int WAKE_DELAY_US = 400;
  localparam int WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int READY_DELAY_US = 10;
  localparam int READY_DELAY_CYC = READY_DELAY_US * CLK_MHZ;
  localparam int LONG_PULSE_NS = 300;
  localparam int LONG_PULSE_CYC = LONG_PULSE_NS * CLK_MHZ / 1000;
  localparam int BYTE_BITS = 8;
  localparam int CRC_W = 15;
  localparam logic [14:0] CRC_SEED = 15'h0010;
  localparam logic [14:0] CRC_TAPS = 15'h4598;
  localparam int DATA_BYTES = 6;
  localparam int CMD_BYTES = 4;
  localparam logic [4:0] BCAST_HDR = 5'h00;
  localparam int ADDR_FLAG_BIT = 7;

  typedef enum logic [3:0] {
    SLW_IDLE = 4'h1,
    SLW_WAKING = 4'h2,
    SLW_READY = 4'h4,
    SLW_ACTIVE = 4'h8
  } slw_link_type;

  typedef enum logic [3:0] {
    SLW_CMD = 4'h1,
    SLW_WDATA = 4'h2,
    SLW_RDATA = 4'h4,
    SLW_SKIP = 4'h8
  } slw_frame_type;

  typedef struct packed {
    logic valid;
    logic is_read;
    logic is_write;
    logic [10:0] code;
  } slw_cmd_type;

  // one crc step per bit, msb first
  function automatic logic [14:0] crc_step(input logic [14:0] c,
                                           input logic din);
    logic fb;
    fb = din ^ c[14];
    crc_step = {c[13:0], 1'b0} ^ (fb ? CRC_TAPS : 15'h0000);
    crc_step[0] = fb;
  endfunction : crc_step
endpackage : slw_pkg

// ---- hw/slw_link.sv ----
// serial link layer: wake detection, byte framing and check code
`timescale 1ns/1ps
// How it works
// RULE_01 - port drops to idle after the idle timeout with no activity
// RULE_02 - in plain serial mode, chip select or clock activity wakes it
// RULE_03 - in pulse mode differential activity wakes; ready after wake delay
// RULE_04 - common-mode activity never counts as a wake event
// RULE_05 - wake needs differential signal held at least 240 ns
// RULE_06 - chain part sends one long positive pulse upward when ready
// RULE_07 - a part already ready sends no wake pulse upward
// RULE_08 - host sends paired long pulses per device, spaced below idle timeout
// RULE_09 - transfers are whole bytes, most significant bit first
// RULE_10 - host keeps chip select low through a whole command sequence
// RULE_11 - write data commits only on chip select rising edge
// RULE_12 - 15-bit check code, seeded 0x0010 before each group
// RULE_13 - feedback is input xor top bit, taps at 3,4,7,8,10,14
// RULE_14 - check word is register shifted left with zero appended
// RULE_15 - first check byte bits 14..7, second bits 6..0 then zero
// RULE_16 - group accepted only if received check word matches
// RULE_17 - read data is followed by its computed check word
// RULE_18 - command order: two command bytes then two check bytes
// RULE_19 - chain write sends farthest device data first, own data last
// RULE_20 - chain read: own data and check first, then pass upper port
// RULE_21 - addressed command answered only on match; chain takes broadcast
// RULE_22 - parallel pulse mode broadcast executes with no returned data
// RULE_23 - broadcast has zeros in first command byte bits 7..3
// RULE_24 - addressed command: bit 7 set, address in bits 6..3
// RULE_25 - command check code spans both command bytes as 16 bits
// RULE_26 - any qualifying activity restarts the idle timeout
module slw_link #(
  parameter int IDLE_CYC = slw_pkg::IDLE_TIMEOUT_CYC,
  parameter int WAKE_CYC = slw_pkg::WAKE_DELAY_CYC,
  parameter int READY_CYC = slw_pkg::READY_DELAY_CYC,
  parameter int NBYTES = slw_pkg::DATA_BYTES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_port_mode_select_strap,
  input wire logic i_chain_mode,
  input wire logic i_core_awake,
  input wire logic [3:0] i_address,
  input wire logic i_chip_select_n,
  input wire logic i_sck,
  input wire logic i_sdi,
  input wire logic i_diff_above,
  input wire logic i_diff_below,
  input wire logic i_upper_sdo,
  input wire logic [8*NBYTES-1:0] i_read_data,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_upper_pulse_pos,
  output logic o_ready,
  output logic o_wake_pulse_busy,
  output slw_pkg::slw_cmd_type o_cmd,
  output logic o_cmd_error,
  output logic [8*NBYTES-1:0] o_write_data,
  output logic o_write_commit,
  output logic o_data_error
);
  localparam int TW = 32;
  localparam int FB = 8 * (NBYTES + 2);
  // bit counter must reach FB itself, where it parks for pass-through
  localparam int CNW = $clog2(FB + 1);
  // pins reset to their idle levels so that no false edge follows reset
  localparam logic [5:0] SYNC_IDLE = 6'h21;

  // ==========================================================
  // input synchronisers
  logic [5:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;
  always_comb begin
    s1_d = {i_chip_select_n, i_sck, i_sdi, i_diff_above, i_diff_below,
            i_upper_sdo};
    s2_d = s1_q;
    s3_d = s2_q;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
      s3_q <= SYNC_IDLE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end
  logic csn, sck, sdi, dabv, dblw, usdo, cs_rise, cs_fall, sck_rise, sck_fall;
  always_comb begin
    csn = s2_q[5];
    sck = s2_q[4];
    sdi = s2_q[3];
    dabv = s2_q[2];
    dblw = s2_q[1];
    usdo = s2_q[0];
    cs_rise = csn & ~s3_q[5];
    cs_fall = ~csn & s3_q[5];
    sck_rise = sck & ~s3_q[4];
    sck_fall = ~sck & s3_q[4];
  end

  // ==========================================================
  // wake detection and link state
  slw_pkg::slw_link_type st_q, st_d;
  logic [TW-1:0] dwell_q, dwell_d, idle_q, idle_d, dly_q, dly_d, pul_q, pul_d;
  logic act, diff_on, live;
  always_comb begin
    // only opposite-sign comparators mean differential; common mode trips both
    diff_on = dabv ^ dblw; // [RULE_04]
    dwell_d = diff_on ? dwell_q + 1 : '0;
    if (i_port_mode_select_strap)
      act = dwell_q == TW'(slw_pkg::WAKE_QUALIFY_CYC - 1)
            && diff_on; // [RULE_03] [RULE_05]
    else
      act = cs_rise | cs_fall | sck_rise | sck_fall; // [RULE_02]
    // decoded link traffic keeps the port awake in pulse mode as well
    live = act | cs_rise | cs_fall | sck_rise | sck_fall;
    st_d = st_q;
    idle_d = live ? '0 : idle_q + 1; // [RULE_26]
    dly_d = dly_q;
    pul_d = (pul_q != '0) ? pul_q - 1 : '0;
    case (st_q)
      slw_pkg::SLW_IDLE: begin
        idle_d = '0;
        if (act) begin
          st_d = slw_pkg::SLW_WAKING;
          dly_d = TW'(i_core_awake ? READY_CYC : WAKE_CYC); // [RULE_03]
        end
      end
      slw_pkg::SLW_WAKING: begin
        dly_d = dly_q - 1;
        if (dly_q <= 1) begin
          st_d = slw_pkg::SLW_READY;
          // only a part that was idle starts the chain wake pulse
          if (i_chain_mode)
            pul_d = TW'(slw_pkg::LONG_PULSE_CYC); // [RULE_06] [RULE_07]
        end
      end
      slw_pkg::SLW_READY, slw_pkg::SLW_ACTIVE: begin
        st_d = csn ? slw_pkg::SLW_READY : slw_pkg::SLW_ACTIVE;
        if (idle_q >= TW'(IDLE_CYC - 1) && !live)
          st_d = slw_pkg::SLW_IDLE; // [RULE_01]
      end
      default: st_d = slw_pkg::SLW_IDLE;
    endcase
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q <= slw_pkg::SLW_IDLE;
      dwell_q <= '0;
      idle_q <= '0;
      dly_q <= '0;
      pul_q <= '0;
    end else begin
      st_q <= st_d;
      dwell_q <= dwell_d;
      idle_q <= idle_d;
      dly_q <= dly_d;
      pul_q <= pul_d;
    end
  end
  logic rdy;
  assign rdy = st_q == slw_pkg::SLW_READY || st_q == slw_pkg::SLW_ACTIVE;

  // ==========================================================
  // framing, check code and response shifter
  slw_pkg::slw_frame_type fr_q, fr_d;
  logic [14:0] crc_q, crc_d;
  logic [31:0] sh_q, sh_d;
  logic [CNW-1:0] cnt_q, cnt_d;
  logic [FB-1:0] wbuf_q, wbuf_d, obuf_q, obuf_d;
  logic [8*NBYTES-1:0] wout_q, wout_d;
  logic wok_q, wok_d, commit_q, commit_d, derr_q, derr_d;
  slw_pkg::slw_cmd_type cmd_q, cmd_d;
  logic cerr_q, cerr_d, sdo_q, sdo_d, oe_q, oe_d;
  logic [15:0] cw;
  logic [31:0] fw;
  logic addr_ok, bcast, mine;
  always_comb begin
    cw = {crc_q, 1'b0}; // [RULE_14]
    // the word as it stands once the current bit is shifted in
    fw = {sh_q[30:0], sdi};
    bcast = fw[31:27] == slw_pkg::BCAST_HDR; // [RULE_23]
    addr_ok = fw[24 + slw_pkg::ADDR_FLAG_BIT]
              && fw[30:27] == i_address; // [RULE_24]
    mine = bcast || (!i_chain_mode && addr_ok); // [RULE_21]
    fr_d = fr_q;
    crc_d = crc_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    wbuf_d = wbuf_q;
    obuf_d = obuf_q;
    wout_d = wout_q;
    wok_d = wok_q;
    commit_d = 1'b0;
    derr_d = 1'b0;
    cmd_d = cmd_q;
    cmd_d.valid = 1'b0;
    cerr_d = 1'b0;
    sdo_d = sdo_q;
    oe_d = oe_q;
    if (csn || !rdy) begin
      fr_d = slw_pkg::SLW_CMD;
      crc_d = slw_pkg::CRC_SEED; // [RULE_12]
      cnt_d = '0;
      oe_d = 1'b0;
      sdo_d = 1'b1;
      if (cs_rise && fr_q == slw_pkg::SLW_WDATA && wok_q) begin
        wout_d = wbuf_q[FB-1 -: 8*NBYTES]; // [RULE_11]
        commit_d = 1'b1;
      end
    end else if (sck_rise) begin
      sh_d = {sh_q[30:0], sdi}; // [RULE_09]
      cnt_d = cnt_q + CNW'(1);
      case (fr_q)
        slw_pkg::SLW_CMD: begin
          // check code spans both command bytes only
          if (cnt_q < CNW'(2 * slw_pkg::BYTE_BITS))
            crc_d = slw_pkg::crc_step(crc_q, sdi); // [RULE_25] [RULE_13]
          if (cnt_q == CNW'(slw_pkg::BYTE_BITS * slw_pkg::CMD_BYTES - 1)) begin
            // order: two command bytes, then two check bytes
            cnt_d = '0;
            crc_d = slw_pkg::CRC_SEED;
            if ({sh_q[14:0], sdi} != cw) begin // [RULE_18] [RULE_16]
              cerr_d = 1'b1;
              fr_d = slw_pkg::SLW_SKIP;
            end else if (!mine) begin
              fr_d = slw_pkg::SLW_SKIP;
            end else begin
              cmd_d = '{1'b1, fw[16], fw[17], fw[26:16]};
              wok_d = 1'b0;
              if (fw[16]) begin
                fr_d = slw_pkg::SLW_RDATA;
                obuf_d = {i_read_data, 16'h0000};
                // parallel (non-chain) pulse-mode broadcast returns nothing
                oe_d = !(i_port_mode_select_strap && !i_chain_mode
                         && bcast); // [RULE_22]
              end else if (fw[17]) begin
                fr_d = slw_pkg::SLW_WDATA;
              end else begin
                fr_d = slw_pkg::SLW_SKIP;
              end
            end
          end
        end
        slw_pkg::SLW_WDATA: begin
          // in a chain the last group seen is this device's own
          wbuf_d = {wbuf_q[FB-2:0], sdi}; // [RULE_19]
          if (cnt_q < CNW'(8 * NBYTES))
            crc_d = slw_pkg::crc_step(crc_q, sdi);
          if (cnt_q == CNW'(FB - 1)) begin
            cnt_d = '0;
            crc_d = slw_pkg::CRC_SEED;
            wok_d = {sh_q[14:0], sdi} == cw; // [RULE_16]
            derr_d = {sh_q[14:0], sdi} != cw;
          end
        end
        default: ;
      endcase
    end else if (sck_fall && fr_q == slw_pkg::SLW_RDATA) begin
      // own bytes, own check word, then whatever comes from above
      if (cnt_q < CNW'(8 * NBYTES)) begin
        sdo_d = obuf_q[FB-1];
        crc_d = slw_pkg::crc_step(crc_q, obuf_q[FB-1]);
        obuf_d = {obuf_q[FB-2:0], 1'b0};
        if (cnt_q == CNW'(8 * NBYTES - 1))
          obuf_d[FB-1 -: 16] = {slw_pkg::crc_step(crc_q, obuf_q[FB-1]),
                                1'b0}; // [RULE_17] [RULE_15]
      end else if (cnt_q < CNW'(FB)) begin
        sdo_d = obuf_q[FB-1];
        obuf_d = {obuf_q[FB-2:0], 1'b0};
      end else begin
        sdo_d = usdo; // [RULE_20]
      end
    end
    if (fr_q == slw_pkg::SLW_RDATA && sck_rise && cnt_q == CNW'(FB))
      cnt_d = cnt_q;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      fr_q <= slw_pkg::SLW_CMD;
      crc_q <= slw_pkg::CRC_SEED;
      sh_q <= '0;
      cnt_q <= '0;
      wbuf_q <= '0;
      obuf_q <= '0;
      wout_q <= '0;
      wok_q <= 1'b0;
      commit_q <= 1'b0;
      derr_q <= 1'b0;
      cmd_q <= '0;
      cerr_q <= 1'b0;
      sdo_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      fr_q <= fr_d;
      crc_q <= crc_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      wbuf_q <= wbuf_d;
      obuf_q <= obuf_d;
      wout_q <= wout_d;
      wok_q <= wok_d;
      commit_q <= commit_d;
      derr_q <= derr_d;
      cmd_q <= cmd_d;
      cerr_q <= cerr_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
    end
  end

  assign o_sdo = sdo_q;
  assign o_sdo_oe = oe_q;
  assign o_upper_pulse_pos = pul_q != '0;
  assign o_wake_pulse_busy = pul_q != '0;
  assign o_ready = rdy;
  assign o_cmd = cmd_q;
  assign o_cmd_error = cerr_q;
  assign o_write_data = wout_q;
  assign o_write_commit = commit_q;
  assign o_data_error = derr_q;

  // ==========================================================
  // checks
  AST_IDLE_DROP: assert property (@(posedge i_clock) disable iff (i_rst)
    rdy && idle_q >= TW'(IDLE_CYC - 1) && !live |=> !rdy) // [RULE_01]
    else $error("no drop to idle after timeout");
  AST_SPI_WAKE: assert property (@(posedge i_clock) disable iff (i_rst)
    st_q == slw_pkg::SLW_IDLE && !i_port_mode_select_strap && cs_fall
    |=> st_q == slw_pkg::SLW_WAKING) // [RULE_02]
    else $error("chip select did not wake port");
  AST_DWELL: assert property (@(posedge i_clock) disable iff (i_rst)
    i_port_mode_select_strap && act
    |-> $past(diff_on, 1) && $past(diff_on, 2)) // [RULE_05]
    else $error("wake qualified too early");
  AST_CM: assert property (@(posedge i_clock) disable iff (i_rst)
    dabv && dblw |=> dwell_q == '0) // [RULE_04]
    else $error("common mode counted as wake");
  AST_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
    rdy && !$past(rdy) && i_chain_mode |-> o_upper_pulse_pos) // [RULE_06]
    else $error("no chain wake pulse");
  AST_NO_PULSE: assert property (@(posedge i_clock) disable iff (i_rst)
    $past(rdy) && rdy && !$past(o_upper_pulse_pos)
    |-> !o_upper_pulse_pos) // [RULE_07]
    else $error("ready part sent wake pulse");
  AST_COMMIT: assert property (@(posedge i_clock) disable iff (i_rst)
    o_write_commit |-> $past(cs_rise)) // [RULE_11]
    else $error("write committed outside chip select rise");
  AST_SEED: assert property (@(posedge i_clock) disable iff (i_rst)
    csn ##1 csn |-> crc_q == slw_pkg::CRC_SEED) // [RULE_12]
    else $error("check code not seeded");
  AST_CMD_OK: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cmd.valid |-> !o_cmd_error && $past(fr_q) == slw_pkg::SLW_CMD) // [RULE_16]
    else $error("command accepted with bad check");
  AST_ADDR: assert property (@(posedge i_clock) disable iff (i_rst)
    o_cmd.valid && i_chain_mode |-> $past(bcast)) // [RULE_21]
    else $error("chain part took addressed command");
endmodule : slw_link

// ---- verification/slw_host_model.sv ----
// host model driving the lower serial port in plain serial mode
`timescale 1ns/1ps
// ==========================================================
// host side of the lower port
module slw_host_model (
  input wire logic i_clock,
  input wire logic i_sdo,
  output logic o_chip_select_n,
  output logic o_sck,
  output logic o_sdi
);
  initial begin
    o_chip_select_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  // check word over n bits of d, msb first
  function automatic logic [15:0] pec_word(input logic [63:0] d, input int n);
    logic [14:0] c;
    logic fb;
    c = 15'h0010;
    for (int i = n - 1; i >= 0; i--) begin
      fb = d[i] ^ c[14];
      c = {c[13] ^ fb, c[12:10], c[9] ^ fb, c[8], c[7] ^ fb, c[6] ^ fb,
           c[5:4], c[3] ^ fb, c[2] ^ fb, c[1:0], fb};
    end
    return {c, 1'b0};
  endfunction : pec_word

  // sdo is read half a clock before sck rises, long after the device moved it
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      o_sdi <= tx[i];
      tick(6);
      @(negedge i_clock);
      rx[i] = i_sdo;
      @(posedge i_clock);
      o_sck <= 1'b1;
      tick(7);
      o_sck <= 1'b0;
    end
  endtask : xfer

  // cs edges double as the long pulses that wake the port
  task automatic select(input logic lvl);
    o_chip_select_n <= lvl;
    if (lvl)
      o_sdi <= ~o_sdi;
    tick(8);
  endtask : select

  // nb bytes then their check word; bad spoils the check word
  task automatic group(input logic [47:0] d, input int nb, input logic bad,
                       output logic [63:0] rx);
    logic [15:0] p;
    logic [7:0] b;
    p = pec_word({16'h0, d}, nb * 8) ^ {7'h0, bad, 8'h0};
    rx = '0;
    for (int i = nb + 1; i >= 0; i--) begin
      xfer(i > 1 ? d[8 * i - 9 -: 8] : p[8 * i + 7 -: 8], b);
      rx = {rx[55:0], b};
    end
  endtask : group
endmodule : slw_host_model

// ---- verification/tb_top.sv ----
// self-checking bench for the serial link block
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb_top;
  localparam int IDLE = 400;
  localparam int WAKE = 150;
  localparam int RDY = 20;
  logic i_clock, i_rst, strap, chain, awake, above, below, upper;
  logic [3:0] addr, a;
  logic [47:0] rdata, wdata, d0;
  logic cs_n, sck, sdi, sdo, commit, derr, cerr, ready, upos;
  logic oe, busy, sdo_line;
  slw_pkg::slw_cmd_type cmd;
  int err_count, num_checks, cycles, npulse, plen, ncommit, n;
  logic [11:0] exp_cmd[$];
  logic [48:0] exp_wr[$];
  logic [63:0] rx;
  logic [10:0] code;

  slw_link #(.IDLE_CYC(IDLE), .WAKE_CYC(WAKE), .READY_CYC(RDY), .NBYTES(6))
  i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_port_mode_select_strap(strap),
    .i_chain_mode(chain), .i_core_awake(awake), .i_address(addr),
    .i_chip_select_n(cs_n), .i_sck(sck), .i_sdi(sdi), .i_diff_above(above),
    .i_diff_below(below), .i_upper_sdo(upper), .i_read_data(rdata),
    .o_sdo(sdo), .o_sdo_oe(oe), .o_upper_pulse_pos(upos), .o_ready(ready),
    .o_wake_pulse_busy(busy), .o_cmd(cmd), .o_cmd_error(cerr),
    .o_write_data(wdata), .o_write_commit(commit), .o_data_error(derr));

  // a released return line floats high, which the host reads as ones
  assign sdo_line = oe ? sdo : 1'b1;

  slw_host_model i_host (.i_clock(i_clock), .i_sdo(sdo_line),
    .o_chip_select_n(cs_n), .o_sck(sck), .o_sdi(sdi));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    num_checks++;
    if (e !== s) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic final_report;
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  // results are taken off the queues as they appear
  always @(negedge i_clock) begin
    if (upos === 1'b1)
      plen++;
    else if (plen > 0) begin
      npulse++;
      chk("pulse_len", slw_pkg::LONG_PULSE_CYC, plen);
      plen = 0;
    end
    if (busy !== upos)
      chk("busy", upos, busy);
    if (cmd.valid === 1'b1 || cerr === 1'b1)
      chk("cmd", exp_cmd.size() ? exp_cmd.pop_front() : 12'hfff,
          {cerr, cerr ? 11'h0 : cmd.code});
    if (commit === 1'b1)
      ncommit++;
    if (commit === 1'b1 || derr === 1'b1)
      chk("wr", exp_wr.size() ? exp_wr.pop_front() : {49{1'b1}},
          {derr, derr ? 48'h0 : wdata});
  end

  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    i_rst = 1'b1;
    strap = 1'b0;
    chain = 1'b1;
    awake = 1'b0;
    above = 1'b0;
    below = 1'b0;
    upper = 1'b1;
    addr = 4'h5;
    rdata = '0;
    d0 = 48'($urandom(59788));
    addr = 4'($urandom);
    repeat (16) @(posedge i_clock);
    i_rst <= 1'b0;
    i_host.tick(4);
    chk("ready", 0, ready);
    i_host.select(1'b0);
    i_host.select(1'b1);
    i_host.tick(WAKE / 2);
    chk("ready", 0, ready);
    i_host.tick(WAKE + 30);
    chk("ready", 1, ready);
    chk("pulses", 1, npulse);
    // second pass spoils our own data group
    for (int k = 0; k < 2; k++) begin
      code = 11'($urandom) & 11'h7fc | 11'h002;
      d0 = 48'({$urandom, $urandom});
      exp_cmd.push_back({1'b0, code});
      exp_wr.push_back(k ? {1'b1, 48'h0} : {1'b0, d0});
      i_host.select(1'b0);
      i_host.group({37'h0, code}, 2, 1'b0, rx);
      i_host.group(~d0, 6, 1'b0, rx);
      i_host.group(d0, 6, k[0], rx);
      chk("early_commit", k, ncommit);
      i_host.select(1'b1);
    end
    exp_cmd.push_back(12'h800);
    i_host.select(1'b0);
    i_host.group(48'h2, 2, 1'b1, rx);
    i_host.select(1'b1);
    code = 11'($urandom) & 11'h7fc | 11'h001;
    rdata <= 48'({$urandom, $urandom});
    upper <= 1'b0;
    exp_cmd.push_back({1'b0, code});
    i_host.select(1'b0);
    i_host.group({37'h0, code}, 2, 1'b0, rx);
    i_host.group('1, 6, 1'b0, rx);
    chk("oe", 1, oe);
    chk("read", {rdata, i_host.pec_word({16'h0, rdata}, 48)}, rx);
    i_host.xfer(8'hff, rx[7:0]);
    chk("pass", 0, rx[7:0]);
    i_host.select(1'b1);
    chk("oe", 0, oe);
    chk("pulses", 1, npulse);
    chain <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      a = k ? addr : addr ^ 4'h9;
      code = 11'($urandom) & 11'h7fc;
      if (k)
        exp_cmd.push_back({1'b0, code});
      i_host.select(1'b0);
      i_host.group({32'h0, 1'b1, a, code}, 2, 1'b0, rx);
      i_host.select(1'b1);
    end
    chain <= 1'b1;
    chk("ready", 1, ready);
    i_host.tick(IDLE + 10);
    chk("ready", 0, ready);
    awake <= 1'b1;
    i_host.select(1'b0);
    i_host.select(1'b1);
    i_host.tick(RDY + 30);
    chk("ready", 1, ready);
    chk("pulses", 2, npulse);
    strap <= 1'b1;
    i_host.tick(IDLE + 10);
    n = 4 + $urandom % 18;
    above <= 1'b1;
    i_host.tick(n);
    below <= 1'b1;
    i_host.tick(60);
    above <= 1'b0;
    below <= 1'b0;
    i_host.tick(RDY + 30);
    chk("ready", 0, ready);
    n = 26 + $urandom % 8;
    below <= 1'b1;
    i_host.tick(n);
    below <= 1'b0;
    i_host.tick(RDY + 60 - n);
    chk("ready", 1, ready);
    chk("pulses", 3, npulse);
    // a parallel part in pulse mode answers a broadcast read with silence
    chain <= 1'b0;
    code = 11'($urandom) & 11'h7fc | 11'h001;
    rdata <= 48'({$urandom, $urandom});
    exp_cmd.push_back({1'b0, code});
    i_host.select(1'b0);
    i_host.group({37'h0, code}, 2, 1'b0, rx);
    i_host.group('1, 6, 1'b0, rx);
    chk("oe", 0, oe);
    chk("silent", {64{1'b1}}, rx);
    i_host.select(1'b1);
    chk("left", 0, exp_cmd.size() + exp_wr.size());
    final_report();
  end
endmodule : tb_top
